// File: sds_consts.svh
// Constants of the supervisor block: offsets, fields, resets, service codes.
`ifndef SDS_CONSTS_SVH
`define SDS_CONSTS_SVH
`define SDS_OFF_CTRL 12'h000
`define SDS_OFF_SVC 12'h004
`define SDS_OFF_STATUS 12'h008
`define SDS_OFF_WARN_LO 12'h00c
`define SDS_OFF_WARN_HI 12'h010
`define SDS_OFF_IRQ_STAT 12'h014
`define SDS_OFF_IRQ_CLR 12'h018
`define SDS_OFF_IRQ_EN 12'h01c
`define SDS_OFF_ATTR 12'h020
`define SDS_CTRL_ALARM_EN 0
`define SDS_CTRL_WARN_EN 1
`define SDS_CTRL_RESET 2'h3
`define SDS_SVC_GET 8'h0e
`define SDS_SVC_SET 8'h10
`define SDS_SVC_RESET 8'h05
`define SDS_SVC_START 8'h06
`define SDS_SVC_STOP 8'h07
`define SDS_SVC_ABORT 8'h4b
`define SDS_SVC_RECOVER 8'h4c
`define SDS_SVC_DIAG 8'h4d
`define SDS_TEST_STANDARD 8'h00
`define SDS_ATTR_ALARM_EN 8'h00
`define SDS_ATTR_WARN_EN 8'h01
`define SDS_ATTR_STATE 8'h02
`define SDS_SELFTEST_NS 1000
`define SDS_SELFTEST_CYC ((`SDS_SELFTEST_NS + 7) / 8)
`define SDS_WARN_INVALID 0
`define SDS_WARN_OVER 1
`define SDS_WARN_UNDER 2
`define SDS_WARN_ELEC 1
`define SDS_WARN_DEGAS 3
`define SDS_IRQ_SVC_DONE 0
`define SDS_IRQ_SVC_ERR 1
`define SDS_IRQ_STATE 2
`endif

// File: sds_pkg.sv
// Types of the supervisor block.
package sds_pkg;
    typedef enum logic [2:0] {
        SDS_SELFTEST = 3'b000,
        SDS_IDLE = 3'b001,
        SDS_RUN = 3'b011,
        SDS_ABORT = 3'b010,
        SDS_FATAL = 3'b110
    } sds_state_t;
endpackage

// File: sds_supervisor.sv
// Supervisor object: service decoder, state machine, warning detail bytes.
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "sds_consts.svh"

module sds_supervisor
    import sds_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reading_valid,
    input wire logic over_range,
    input wire logic under_range,
    input wire logic diaphragm_elec_warn,
    input wire logic pirani_elec_warn,
    input wire logic degas_press_high,
    input wire logic poll_io_valid,
    input wire logic app_abort,
    input wire logic app_recover,
    input wire logic fault_fatal,
    input wire logic selftest_fail,
    output logic meas_valid,
    output logic alarm_en,
    output logic warn_en,
    output logic [2:0] sup_state,
    output logic irq
);

    sds_state_t state_reg;
    sds_state_t state_next;
    logic [1:0] en_reg;
    logic [7:0] attr_rdata_reg;
    logic svc_err_reg;
    logic [15:0] st_cnt_reg;
    logic [2:0] irq_stat_reg;
    logic [2:0] irq_en_reg;
    logic [55:0] warn_reg;
    logic [5:0] s1_reg;
    logic [5:0] s2_reg;
    logic [3:0] c1_reg;
    logic [3:0] c2_reg;
    logic wr_acc;
    logic rd_acc;
    logic svc_go;
    logic [7:0] svc_code;
    logic [7:0] svc_attr;
    logic [7:0] svc_val;
    logic svc_known;
    logic poll_rise;
    logic poll_d_reg;
    logic [31:0] rdata_next;
    logic rd_err;
    logic [55:0] warn_next;
    logic [2:0] irq_set;
    logic st_restart;
    logic warn_off;

    // Single-cycle access phase: the slave always answers at once.
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign svc_go = wr_acc && paddr == `SDS_OFF_SVC;
    assign svc_code = pwdata[7:0];
    assign svc_attr = pwdata[15:8];
    assign svc_val = pwdata[23:16];
    // Reset and accepted diagnostics both restart a self-test in progress.
    assign st_restart = svc_go && (svc_code == `SDS_SVC_RESET ||
        (svc_code == `SDS_SVC_DIAG && svc_known));

    // Asynchronous condition inputs pass two flip-flops first.
    always_ff @(posedge clk) begin
        s1_reg <= {degas_press_high, pirani_elec_warn, diaphragm_elec_warn,
                   under_range, over_range, reading_valid};
        s2_reg <= s1_reg;
        c1_reg <= {selftest_fail, fault_fatal, app_recover, app_abort};
        c2_reg <= c1_reg;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            poll_d_reg <= 1'b0;
        end else begin
            poll_d_reg <= poll_io_valid;
        end
    end
    assign poll_rise = poll_io_valid && !poll_d_reg;

    always_comb begin
        case (svc_code)
            `SDS_SVC_GET, `SDS_SVC_SET, `SDS_SVC_RESET, `SDS_SVC_START,
            `SDS_SVC_STOP, `SDS_SVC_ABORT, `SDS_SVC_RECOVER: begin
                svc_known = 1'b1;
            end
            `SDS_SVC_DIAG: begin
                svc_known = svc_val == `SDS_TEST_STANDARD;
            end
            default: begin
                svc_known = 1'b0;
            end
        endcase
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SDS_SELFTEST: begin
                if (st_cnt_reg == 16'(`SDS_SELFTEST_CYC)) begin
                    state_next = c2_reg[3] ? SDS_FATAL : SDS_IDLE;
                end
            end
            SDS_IDLE: begin
                if ((svc_go && svc_code == `SDS_SVC_START) || poll_rise) begin
                    state_next = SDS_RUN;
                end
            end
            SDS_RUN: begin
                if (svc_go && svc_code == `SDS_SVC_STOP) begin
                    state_next = SDS_IDLE;
                end
            end
            SDS_ABORT: begin
                if ((svc_go && svc_code == `SDS_SVC_RECOVER) || c2_reg[1]) begin
                    state_next = SDS_IDLE;
                end
            end
            SDS_FATAL: begin
                state_next = SDS_FATAL;
            end
            default: begin
                state_next = SDS_SELFTEST;
            end
        endcase
        if (state_reg != SDS_FATAL) begin
            if ((svc_go && svc_code == `SDS_SVC_ABORT) || c2_reg[0]) begin
                state_next = SDS_ABORT;
            end
            if (svc_go && svc_code == `SDS_SVC_DIAG && svc_known &&
                state_reg != SDS_ABORT) begin
                state_next = SDS_SELFTEST;
            end
            if (svc_go && svc_code == `SDS_SVC_RESET) begin
                state_next = SDS_SELFTEST;
            end
            if (c2_reg[2]) begin
                state_next = SDS_FATAL;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= SDS_SELFTEST;
            st_cnt_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            if (state_next == SDS_SELFTEST &&
                (state_reg != SDS_SELFTEST || st_restart)) begin
                st_cnt_reg <= 16'h0000;
            end else if (state_reg == SDS_SELFTEST) begin
                st_cnt_reg <= st_cnt_reg + 16'h0001;
            end
        end
    end

    // Enables and attribute reads through the service port.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            en_reg <= `SDS_CTRL_RESET;
            attr_rdata_reg <= 8'h00;
            svc_err_reg <= 1'b0;
        end else begin
            if (wr_acc && paddr == `SDS_OFF_CTRL) begin
                en_reg <= pwdata[1:0];
            end
            if (svc_go) begin
                svc_err_reg <= !svc_known;
                if (svc_known && svc_code == `SDS_SVC_SET) begin
                    if (svc_attr == `SDS_ATTR_ALARM_EN) begin
                        en_reg[`SDS_CTRL_ALARM_EN] <= svc_val[0];
                    end else if (svc_attr == `SDS_ATTR_WARN_EN) begin
                        en_reg[`SDS_CTRL_WARN_EN] <= svc_val[0];
                    end
                end
                if (svc_known && svc_code == `SDS_SVC_GET) begin
                    case (svc_attr)
                        `SDS_ATTR_ALARM_EN: begin
                            attr_rdata_reg <= {7'h00, en_reg[0]};
                        end
                        `SDS_ATTR_WARN_EN: begin
                            attr_rdata_reg <= {7'h00, en_reg[1]};
                        end
                        `SDS_ATTR_STATE: begin
                            attr_rdata_reg <= {5'h00, state_reg};
                        end
                        default: begin
                            attr_rdata_reg <= 8'h00;
                        end
                    endcase
                end
            end
        end
    end

    // Warning bytes follow live conditions, gated by the warning enable.
    assign warn_off = (wr_acc && paddr == `SDS_OFF_CTRL &&
        !pwdata[`SDS_CTRL_WARN_EN]) || (svc_go && svc_known &&
        svc_code == `SDS_SVC_SET && svc_attr == `SDS_ATTR_WARN_EN &&
        !svc_val[0]);

    always_comb begin
        warn_next = 56'h0;
        warn_next[`SDS_WARN_INVALID] = !s2_reg[0];
        warn_next[`SDS_WARN_OVER] = s2_reg[1];
        warn_next[`SDS_WARN_UNDER] = s2_reg[2];
        warn_next[16 + `SDS_WARN_ELEC] = s2_reg[3];
        warn_next[32 + `SDS_WARN_ELEC] = s2_reg[4];
        warn_next[48 + `SDS_WARN_DEGAS] = s2_reg[5];
        if (!en_reg[`SDS_CTRL_WARN_EN] || warn_off) begin
            warn_next = 56'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            warn_reg <= 56'h0;
        end else begin
            warn_reg <= warn_next;
        end
    end

    assign irq_set = {state_reg != state_next, svc_go && !svc_known, svc_go};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_stat_reg <= 3'h0;
            irq_en_reg <= 3'h0;
        end else begin
            if (wr_acc && paddr == `SDS_OFF_IRQ_EN) begin
                irq_en_reg <= pwdata[2:0];
            end
            if (wr_acc && paddr == `SDS_OFF_IRQ_CLR) begin
                irq_stat_reg <= (irq_stat_reg & ~pwdata[2:0]) | irq_set;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_set;
            end
        end
    end

    always_comb begin
        rdata_next = 32'h0;
        rd_err = 1'b0;
        case (paddr)
            `SDS_OFF_CTRL: rdata_next = {30'h0, en_reg};
            `SDS_OFF_SVC: rdata_next = {23'h0, svc_err_reg, attr_rdata_reg};
            `SDS_OFF_STATUS: rdata_next = {28'h0, meas_valid, state_reg};
            `SDS_OFF_WARN_LO: rdata_next = warn_reg[31:0];
            `SDS_OFF_WARN_HI: rdata_next = {8'h0, warn_reg[55:32]};
            `SDS_OFF_IRQ_STAT: rdata_next = {29'h0, irq_stat_reg};
            `SDS_OFF_IRQ_CLR: rdata_next = 32'h0;
            `SDS_OFF_IRQ_EN: rdata_next = {29'h0, irq_en_reg};
            default: rd_err = 1'b1;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
            pready <= 1'b0;
            meas_valid <= 1'b0;
            alarm_en <= 1'b1;
            warn_en <= 1'b1;
            sup_state <= 3'h0;
            irq <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && rd_err;
            prdata <= (psel && !penable && !pwrite) ? rdata_next : 32'h0;
            meas_valid <= state_next == SDS_RUN;
            alarm_en <= en_reg[`SDS_CTRL_ALARM_EN];
            warn_en <= en_reg[`SDS_CTRL_WARN_EN];
            sup_state <= state_next;
            irq <= |(irq_stat_reg & irq_en_reg);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    en_reset_a: assert property ($rose(rst_n) |-> en_reg == 2'b11)
        else $error("enables not set after reset");
    warn_gate_a: assert property (!en_reg[1] |=> warn_reg == 56'h0)
        else $error("warning set while disabled");
    warn_clear_a: assert property (warn_off |=> warn_reg == 56'h0)
        else $error("warning not cleared on disable");
    warn_live_a: assert property ($past(rst_n) && en_reg[1] &&
        $past(en_reg[1]) |-> warn_reg[0] == !$past(s2_reg[0]))
        else $error("reading invalid bit wrong");
    degas_bit_a: assert property ($past(rst_n) && en_reg[1] &&
        $past(en_reg[1]) |-> warn_reg[51] == $past(s2_reg[5]))
        else $error("degas bit wrong");
    zero_bytes_a: assert property (warn_reg[15:8] == 8'h0 &&
        warn_reg[31:24] == 8'h0 && warn_reg[47:40] == 8'h0)
        else $error("reserved warning byte set");
    reset_svc_a: assert property (svc_go &&
        svc_code == `SDS_SVC_RESET && state_reg != SDS_FATAL &&
        !c2_reg[2] |=> state_reg == SDS_SELFTEST)
        else $error("reset service ignored");
    diag_abort_a: assert property (state_reg == SDS_ABORT &&
        svc_go && svc_code == `SDS_SVC_DIAG && !c2_reg[2] && !c2_reg[1] |=>
        state_reg == SDS_ABORT)
        else $error("diagnostics left abort");
    start_run_a: assert property (state_reg == SDS_IDLE && svc_go &&
        svc_code == `SDS_SVC_START && !c2_reg[0] && !c2_reg[2] |=>
        state_reg == SDS_RUN ##1 meas_valid)
        else $error("start did not reach running");
    meas_run_a: assert property (meas_valid |-> state_reg == SDS_RUN)
        else $error("measurement valid outside running");
    unknown_svc_a: assert property (svc_go && !svc_known |=>
        svc_err_reg && $stable(en_reg))
        else $error("unknown service not refused");
    stop_idle_a: assert property (state_reg == SDS_RUN && svc_go &&
        svc_code == `SDS_SVC_STOP && !c2_reg[0] && !c2_reg[2] |=>
        state_reg == SDS_IDLE)
        else $error("stop did not reach idle");
    poll_run_a: assert property (state_reg == SDS_IDLE && poll_rise &&
        !svc_go && !c2_reg[0] && !c2_reg[2] |=> state_reg == SDS_RUN)
        else $error("polled message did not start running");
    abort_svc_a: assert property (state_reg != SDS_FATAL && svc_go &&
        svc_code == `SDS_SVC_ABORT && !c2_reg[2] |=> state_reg == SDS_ABORT)
        else $error("abort service ignored");
    recover_a: assert property (state_reg == SDS_ABORT && svc_go &&
        svc_code == `SDS_SVC_RECOVER && !c2_reg[0] && !c2_reg[2] |=>
        state_reg == SDS_IDLE)
        else $error("recover did not reach idle");
    diag_restart_a: assert property (state_reg == SDS_SELFTEST &&
        st_restart && !c2_reg[2] |=> st_cnt_reg == 16'h0000)
        else $error("diagnostics did not restart self-test");

    run_poll_c: cover property (state_reg == SDS_IDLE && poll_rise
        ##1 state_reg == SDS_RUN);
    abort_rec_c: cover property (state_reg == SDS_ABORT ##[1:20]
        state_reg == SDS_IDLE);
    warn_off_c: cover property ($fell(en_reg[1]));
    diag_restart_c: cover property (state_reg == SDS_SELFTEST && st_restart);
    selftest_fail_c: cover property (state_reg == SDS_SELFTEST ##1
        state_reg == SDS_FATAL);

endmodule

// File: sds_apb_master.sv
// APB master standing in for the fieldbus master that issues services.
`timescale 1ns/1ps
module sds_apb_master (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    int timeouts = 0;

    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end

    // One transfer; the request stands until pready is sampled high or 16 cycles of the access phase have passed.
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] r,
                        output logic e);
        int n;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        if (pready !== 1'h1)
            timeouts++;
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // Released lines carry a changed pattern, not the last value.
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// File: sds_tb.sv
// Self-checking bench for the supervisor block.
`timescale 1ns/1ps
`include "sds_consts.svh"
module tb import sds_pkg::*;;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic er, meas_valid, alarm_en, warn_en, irq;
    logic [2:0] sup_state;
    logic [5:0] sens = 6'h01;
    logic poll = 1'h0;
    logic abrt = 1'h0;
    logic recov = 1'h0;
    logic fatal = 1'h0;
    logic stf = 1'h0;
    int failures = 0;
    int n_checks = 0;
    int seed = 92;

    always #4 clk = ~clk;

    sds_apb_master u_mst (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    sds_supervisor u_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reading_valid(sens[0]), .over_range(sens[1]),
        .under_range(sens[2]), .diaphragm_elec_warn(sens[3]),
        .pirani_elec_warn(sens[4]), .degas_press_high(sens[5]),
        .poll_io_valid(poll), .app_abort(abrt), .app_recover(recov),
        .fault_fatal(fatal), .selftest_fail(stf), .meas_valid(meas_valid),
        .alarm_en(alarm_en), .warn_en(warn_en), .sup_state(sup_state),
        .irq(irq));

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic print_verdict();
        failures += u_mst.timeouts;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wr(logic [11:0] a, logic [31:0] d);
        u_mst.xfer(1'h1, a, d, rd, er);
        if (u_mst.timeouts != 0)
            print_verdict();
    endtask

    task automatic rdchk(logic [11:0] a, logic [31:0] exp, string nm);
        u_mst.xfer(1'h0, a, 32'h0, rd, er);
        if (u_mst.timeouts != 0)
            print_verdict();
        chk(nm, rd, exp);
    endtask

    task automatic svc(logic [7:0] code, logic [7:0] attr, logic [7:0] v);
        wr(`SDS_OFF_SVC, {8'h00, v, attr, code});
    endtask

    // Readings are valid only while running.
    task automatic st(sds_state_t s);
        repeat (3) @(posedge clk);
        chk("state", {29'h0, sup_state}, {29'h0, s});
        chk("meas_valid", {31'h0, meas_valid}, {31'h0, s == SDS_RUN});
    endtask

    task automatic wait_st(sds_state_t s);
        int n;
        n = 0;
        while (sup_state !== s && n < 400) begin
            @(posedge clk);
            n++;
        end
        chk("state wait", {29'h0, sup_state}, {29'h0, s});
        if (sup_state !== s)
            print_verdict();
    endtask

    // Expected warning bytes 0 to 7 from the live sensor levels.
    function automatic logic [63:0] warn_model(logic [5:0] s, logic e);
        logic [63:0] w;
        w = 64'h0;
        w[2:0] = {s[2], s[1], ~s[0]};
        w[17] = s[3];
        w[33] = s[4];
        w[51] = s[5];
        return e ? w : 64'h0;
    endfunction

    task automatic warn_chk(logic e);
        logic [63:0] w;
        repeat (6) @(posedge clk);
        w = warn_model(sens, e);
        rdchk(`SDS_OFF_WARN_LO, w[31:0], "warn_lo");
        rdchk(`SDS_OFF_WARN_HI, w[63:32], "warn_hi");
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        chk("enables", {30'h0, alarm_en, warn_en}, 32'h3);
        rdchk(`SDS_OFF_CTRL, 32'h3, "ctrl");
        chk("selftest", {29'h0, sup_state}, 32'h0);
        wait_st(SDS_IDLE);
        for (int i = 0; i < 8; i++) begin
            sens <= 6'($random(seed));
            warn_chk(1'h1);
        end
        sens <= 6'h3e;
        warn_chk(1'h1);
        wr(`SDS_OFF_CTRL, 32'h1);
        warn_chk(1'h0);
        sens <= 6'h31;
        warn_chk(1'h0);
        wr(`SDS_OFF_CTRL, 32'h3);
        warn_chk(1'h1);
        svc(`SDS_SVC_SET, `SDS_ATTR_WARN_EN, 8'h00);
        st(SDS_IDLE);
        chk("warn_en", {31'h0, warn_en}, 32'h0);
        svc(`SDS_SVC_GET, `SDS_ATTR_WARN_EN, 8'h00);
        rdchk(`SDS_OFF_SVC, 32'h0, "get warn_en");
        svc(`SDS_SVC_SET, `SDS_ATTR_WARN_EN, 8'h01);
        svc(`SDS_SVC_GET, `SDS_ATTR_STATE, 8'h00);
        rdchk(`SDS_OFF_SVC, {29'h0, SDS_IDLE}, "get state");
        svc(`SDS_SVC_START, 8'h00, 8'h00);
        st(SDS_RUN);
        svc(`SDS_SVC_STOP, 8'h00, 8'h00);
        st(SDS_IDLE);
        poll <= 1'h1;
        st(SDS_RUN);
        poll <= 1'h0;
        svc(`SDS_SVC_ABORT, 8'h00, 8'h00);
        st(SDS_ABORT);
        svc(`SDS_SVC_DIAG, 8'h00, `SDS_TEST_STANDARD);
        st(SDS_ABORT);
        svc(`SDS_SVC_RECOVER, 8'h00, 8'h00);
        st(SDS_IDLE);
        abrt <= 1'h1;
        wait_st(SDS_ABORT);
        abrt <= 1'h0;
        recov <= 1'h1;
        wait_st(SDS_IDLE);
        recov <= 1'h0;
        svc(`SDS_SVC_START, 8'h00, 8'h00);
        svc(`SDS_SVC_DIAG, 8'h00, `SDS_TEST_STANDARD);
        st(SDS_SELFTEST);
        svc(`SDS_SVC_DIAG, 8'h00, `SDS_TEST_STANDARD);
        st(SDS_SELFTEST);
        wait_st(SDS_IDLE);
        svc(`SDS_SVC_START, 8'h00, 8'h00);
        svc(`SDS_SVC_RESET, 8'h00, 8'h00);
        st(SDS_SELFTEST);
        wait_st(SDS_IDLE);
        wr(`SDS_OFF_IRQ_EN, 32'h2);
        wr(`SDS_OFF_IRQ_CLR, 32'h7);
        svc(8'h99, 8'h00, 8'h00);
        st(SDS_IDLE);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(`SDS_OFF_IRQ_CLR, 32'h7);
        svc(`SDS_SVC_DIAG, 8'h00, 8'h01);
        st(SDS_IDLE);
        rdchk(`SDS_OFF_SVC, 32'h101, "diag selector err");
        wr(`SDS_OFF_IRQ_CLR, 32'h7);
        st(SDS_IDLE);
        chk("irq clr", {31'h0, irq}, 32'h0);
        wr(`SDS_OFF_IRQ_EN, 32'h0);
        svc(8'h99, 8'h00, 8'h00);
        st(SDS_IDLE);
        chk("irq mask", {31'h0, irq}, 32'h0);
        rdchk(`SDS_OFF_IRQ_STAT, 32'h3, "irq_stat");
        rdchk(12'h100, 32'h0, "unmapped rd");
        chk("pslverr", {31'h0, er}, 32'h1);
        fatal <= 1'h1;
        wait_st(SDS_FATAL);
        svc(`SDS_SVC_RESET, 8'h00, 8'h00);
        st(SDS_FATAL);
        svc(`SDS_SVC_DIAG, 8'h00, `SDS_TEST_STANDARD);
        st(SDS_FATAL);
        wr(`SDS_OFF_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        chk("enables off", {30'h0, alarm_en, warn_en}, 32'h0);
        rst_n <= 1'h0;
        fatal <= 1'h0;
        stf <= 1'h1;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        chk("enables rst", {30'h0, alarm_en, warn_en}, 32'h3);
        chk("selftest rst", {29'h0, sup_state}, 32'h0);
        wait_st(SDS_FATAL);
        print_verdict();
    end
endmodule
